/* design/awti_top.sv */
// Async wait configuration, turnaround and ready timeout interrupt
module awti_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Memory port sequencer
  input  wire logic        strobe_end,
  output logic             acc_grant,
  output logic             strobe_extend,
  output logic             acc_end,
  output logic             timeout_abort,
  // Pins and interrupt
  input  wire logic        async_ready_input,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////
  awti_pkg::awti_cfg_t   cfg;
  awti_pkg::awti_state_t state;
  awti_pkg::awti_state_t next_state;
  logic                  ready_input_enable;
  logic                  timeout_raw_flag;
  logic                  timeout_masked_flag;
  logic                  irq_en;
  logic [awti_pkg::LIMIT_W-1:0] wait_count;
  logic [3:0]            turn_count;
  logic                  ready_level;
  logic                  timeout_pulse;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  // Ready comes from another clock domain, so it is filtered first
  awti_sync #(
    .RESET_VAL (1'b0)
  ) u_ready_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (async_ready_input),
    .level    (ready_level)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  wire setup_ph  = psel && !penable;
  wire access_ph = psel && penable;
  wire wr_en     = access_ph && pwrite;
  wire hit_cfg   = (paddr == awti_pkg::OFS_WAIT_CFG);
  wire hit_raw   = (paddr == awti_pkg::OFS_RAW);
  wire hit_msk   = (paddr == awti_pkg::OFS_MASKED);
  wire hit_set   = (paddr == awti_pkg::OFS_EN_SET);
  wire hit_clr   = (paddr == awti_pkg::OFS_EN_CLR);
  wire hit_cs    = (paddr == awti_pkg::OFS_CS_CTRL);
  wire mapped    = hit_cfg || hit_raw || hit_msk || hit_set || hit_clr
                   || hit_cs;
  wire wbit      = pwdata[awti_pkg::FLAG_BIT];
  wire flag_clr  = wr_en && wbit && (hit_raw || hit_msk);
  wire en_set    = wr_en && wbit && hit_set;
  wire en_clr    = wr_en && wbit && hit_clr;

  // Zero-wait slave; read data is latched during the setup phase
  assign pready = 1'b1;

  wire [31:0] rd_cfg = {1'b0, cfg.ready_polarity, 19'h0,
                        cfg.turnaround_cycles, cfg.max_extended_wait};
  wire [31:0] rd_raw = {31'h0, timeout_raw_flag};
  wire [31:0] rd_msk = {31'h0, timeout_masked_flag};
  wire [31:0] rd_en  = {31'h0, irq_en};
  wire [31:0] rd_cs  = {3'h0, ready_input_enable, 28'h0};
  wire [31:0] rd_mux = hit_cfg ? rd_cfg :
                       hit_raw ? rd_raw :
                       hit_msk ? rd_msk :
                       (hit_set || hit_clr) ? rd_en :
                       hit_cs  ? rd_cs  : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= pwrite ? 32'h0 : rd_mux;
      pslverr <= !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.ready_polarity    <= awti_pkg::RST_POL;
      cfg.turnaround_cycles <= awti_pkg::RST_TA;
      cfg.max_extended_wait <= awti_pkg::RST_MW;
      ready_input_enable    <= awti_pkg::RST_AE;
    end else if (wr_en && hit_cfg) begin
      cfg.ready_polarity    <= pwdata[awti_pkg::POL_BIT];
      cfg.turnaround_cycles <= pwdata[awti_pkg::TA_MSB:awti_pkg::TA_LSB];
      cfg.max_extended_wait <= pwdata[awti_pkg::MW_MSB:awti_pkg::MW_LSB];
    end else if (wr_en && hit_cs) begin
      ready_input_enable    <= pwdata[awti_pkg::AE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ready qualification
  wire ready_active = ready_input_enable
                      && (ready_level == cfg.ready_polarity);

  // Limit in cycles; field zero gives an immediate cut-off
  wire [awti_pkg::LIMIT_W-1:0] wait_limit =
    awti_pkg::LIMIT_W'({4'h0, cfg.max_extended_wait})
    << awti_pkg::WAIT_UNIT_SHIFT;
  wire [awti_pkg::LIMIT_W-1:0] wait_inc =
    awti_pkg::LIMIT_W'(wait_count + 1'b1);
  wire wait_over = (wait_inc >= wait_limit);
  wire turn_done = (turn_count ==
                    4'({1'b0, cfg.turnaround_cycles}) + awti_pkg::TA_EXTRA_M1);

  ////////////////////////////////////////////////////////////////////////
  // Access state machine
  // Strobe end counts only in idle; a late pulse cannot restart a turn
  wire start_ext = (state == awti_pkg::ST_IDLE) && strobe_end
                   && ready_active;
  wire end_plain = (state == awti_pkg::ST_IDLE) && strobe_end
                   && !ready_active;
  wire ext_release = (state == awti_pkg::ST_EXTEND) && !ready_active;
  assign timeout_pulse = (state == awti_pkg::ST_EXTEND) && ready_active
                         && wait_over;

  always_comb begin
    next_state = state;
    case (state)
      awti_pkg::ST_IDLE: begin
        if (start_ext) begin
          next_state = awti_pkg::ST_EXTEND;
        end else if (end_plain) begin
          next_state = awti_pkg::ST_TURN;
        end
      end
      awti_pkg::ST_EXTEND: begin
        if (ext_release || timeout_pulse) begin
          next_state = awti_pkg::ST_TURN;
        end
      end
      awti_pkg::ST_TURN: begin
        if (turn_done) begin
          next_state = awti_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = awti_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= awti_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Wait and turnaround counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_count <= '0;
      turn_count <= 4'h0;
    end else begin
      wait_count <= (state == awti_pkg::ST_EXTEND) ? wait_inc : '0;
      turn_count <= (state == awti_pkg::ST_TURN) ?
                    4'(turn_count + 4'h1) : 4'h0;
    end
  end

  assign acc_grant     = (state == awti_pkg::ST_IDLE);
  assign strobe_extend = (state == awti_pkg::ST_EXTEND);
  assign acc_end       = end_plain || ext_release || timeout_pulse;
  assign timeout_abort = timeout_pulse;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt flags; a timeout wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_raw_flag    <= 1'b0;
      timeout_masked_flag <= 1'b0;
      irq_en              <= 1'b0;
    end else begin
      if (timeout_pulse) begin
        timeout_raw_flag <= 1'b1;
      end else if (flag_clr) begin
        timeout_raw_flag <= 1'b0;
      end
      if (timeout_pulse && irq_en) begin
        timeout_masked_flag <= 1'b1;
      end else if (flag_clr) begin
        timeout_masked_flag <= 1'b0;
      end
      if (en_set) begin
        irq_en <= 1'b1;
      end else if (en_clr) begin
        irq_en <= 1'b0;
      end
    end
  end

  // Disabling gates the request at once without losing the flag
  assign irq = timeout_masked_flag && irq_en;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_extend_a: assert property (
    (start_ext) |=> strobe_extend [*1] ##0 (state == awti_pkg::ST_EXTEND))
    else $error("active ready did not extend the strobe");

  gap_min_a: assert property (
    (acc_end && cfg.turnaround_cycles == 3'h0 && !(wr_en && hit_cfg))
    |=> !acc_grant [*2] ##1 acc_grant)
    else $error("turnaround gap is not two cycles");

  gap_hold_a: assert property (
    acc_end |=> !acc_grant ##1 !acc_grant)
    else $error("grant returned inside turnaround");

  wait_bound_a: assert property (
    strobe_extend |-> (wait_count < wait_limit || wait_limit == '0))
    else $error("extension ran past its limit");

  timeout_end_a: assert property (
    timeout_pulse |-> acc_end ##1 !strobe_extend)
    else $error("timeout did not end the access");

  raw_set_a: assert property (
    timeout_pulse |=> timeout_raw_flag)
    else $error("raw flag missed a timeout");

  flag_clear_a: assert property (
    (flag_clr && !timeout_pulse) |=> !timeout_raw_flag
    && !timeout_masked_flag)
    else $error("flag clear left a flag standing");

  masked_gate_a: assert property (
    $rose(timeout_masked_flag) |-> $past(irq_en) && $past(timeout_pulse))
    else $error("masked flag set while disabled");

  enable_set_a: assert property (
    en_set |=> irq_en ##0 (rd_en == 32'h1))
    else $error("enable set did not take");

  enable_clr_a: assert property (
    en_clr |=> !irq_en)
    else $error("enable clear did not take");

  ready_gate_a: assert property (
    (strobe_end && acc_grant && !ready_input_enable) |=> !strobe_extend)
    else $error("ready honoured while disabled");

  irq_hold_a: assert property (
    (irq && !flag_clr && !en_clr) |=> irq)
    else $error("interrupt dropped without a clear");

  // Grant-less cycles since the last access ended, for the gap check only
  logic [3:0] gap_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt <= 4'h0;
    end else if (acc_end) begin
      gap_cnt <= 4'h0;
    end else if (!acc_grant) begin
      gap_cnt <= 4'(gap_cnt + 4'h1);
    end
  end

  gap_exact_a: assert property (
    $rose(acc_grant) |-> (gap_cnt == 4'({1'b0, cfg.turnaround_cycles})
    + awti_pkg::TA_EXTRA_M1 + 4'h1))
    else $error("turnaround gap is not field plus two");

  grant_turn_a: assert property (
    (state == awti_pkg::ST_TURN && turn_done) |=> acc_grant)
    else $error("grant did not return after turnaround");

  pol_release_a: assert property (
    (strobe_extend && ready_level != cfg.ready_polarity) |-> acc_end
    && !timeout_abort)
    else $error("inactive ready did not release the strobe");

  limit_hit_a: assert property (
    (strobe_extend && ready_active && wait_inc == wait_limit)
    |-> timeout_abort)
    else $error("extension outlived its limit");

  raw_hold_a: assert property (
    (!flag_clr && !timeout_pulse) |=> $stable(timeout_raw_flag))
    else $error("raw flag changed without cause");

  mask_off_a: assert property (
    (timeout_pulse && !irq_en && !timeout_masked_flag)
    |=> !timeout_masked_flag)
    else $error("masked flag set while disabled on timeout");

  masked_hold_a: assert property (
    (!flag_clr && !timeout_pulse) |=> $stable(timeout_masked_flag))
    else $error("masked flag changed without cause");

  en_hold_a: assert property (
    (!en_set && !en_clr) |=> $stable(irq_en))
    else $error("enable changed without a write");

  clr_read_a: assert property (
    en_clr |=> (rd_en == 32'h0))
    else $error("enable bits still read one");

  plain_end_a: assert property (
    (strobe_end && acc_grant && !ready_active) |-> acc_end && !timeout_abort)
    else $error("unextended access did not end at once");

  irq_src_a: assert property (
    irq |-> (timeout_masked_flag && irq_en))
    else $error("interrupt raised without a masked flag");

  extend_c: cover property (start_ext ##[1:20] ext_release);
  timeout_c: cover property (timeout_pulse && irq_en);
  clear_c: cover property (irq ##[1:50] flag_clr);
  plain_c: cover property (end_plain);
  low_pol_c: cover property (start_ext && !cfg.ready_polarity);
endmodule : awti_top

/* include/awti_pkg.sv */
// Package: offsets, fields, resets and types of the wait/timeout block
package awti_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_WAIT_CFG = 8'h00;
  localparam logic [7:0] OFS_RAW      = 8'h04;
  localparam logic [7:0] OFS_MASKED   = 8'h08;
  localparam logic [7:0] OFS_EN_SET   = 8'h0C;
  localparam logic [7:0] OFS_EN_CLR   = 8'h10;
  localparam logic [7:0] OFS_CS_CTRL  = 8'h14;
  // Field positions
  localparam int unsigned POL_BIT  = 30;
  localparam int unsigned TA_LSB   = 8;
  localparam int unsigned TA_MSB   = 10;
  localparam int unsigned MW_LSB   = 0;
  localparam int unsigned MW_MSB   = 7;
  localparam int unsigned FLAG_BIT = 0;
  localparam int unsigned AE_BIT   = 28;
  // Reset values
  localparam logic       RST_POL = 1'b1;
  localparam logic [2:0] RST_TA  = 3'h3;
  localparam logic [7:0] RST_MW  = 8'h80;
  localparam logic       RST_AE  = 1'b0;
  // Timing
  localparam int unsigned WAIT_UNIT_SHIFT = 4;
  localparam logic [3:0]  TA_EXTRA_M1     = 4'h1;
  localparam int unsigned LIMIT_W         = 12;

  typedef struct packed {
    logic       ready_polarity;
    logic [2:0] turnaround_cycles;
    logic [7:0] max_extended_wait;
  } awti_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_EXTEND = 2'b01,
    ST_TURN   = 2'b11
  } awti_state_t;
endpackage : awti_pkg

/* design/awti_sync.sv */
// Three-flop pin synchroniser with agreement filter
module awti_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and filtered level
  input  wire logic async_in,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;
  wire  agree = (s2 == s3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= RESET_VAL;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      // Glitch shorter than one cycle never reaches level
      if (agree) begin
        level <= s3;
      end
    end
  end
endmodule : awti_sync

/* verif/awti_mem_model.sv */
// Behavioural async memory that holds its ready pin active for a set time
module awti_mem_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Command from bench
  input  wire logic        go,
  input  wire logic [11:0] len,
  input  wire logic        active_high,
  // Ready pin
  output logic             ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] cnt;
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt <= 12'h000;
    else if (go)
      cnt <= len;
    else if (cnt != 12'h000)
      cnt <= cnt - 12'h001;
  end
  // Idle level is the inactive one, so no stale extension is left behind
  assign ready = (cnt != 12'h000) ? active_high : ~active_high;
endmodule : awti_mem_model

/* verif/tb.sv */
// Self-checking bench for the wait and timeout block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        strobe_end, acc_grant, strobe_extend, acc_end;
  logic        timeout_abort, irq, rdy, go, pol, to, e, slv, g;
  logic [7:0]  paddr;
  logic [11:0] len;
  logic [31:0] pwdata, prdata, q;
  int          error_cnt, n_tests, cyc, ext, gap;
  //////////////////////////////////////////////////////////////////////////
  awti_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strobe_end(strobe_end), .acc_grant(acc_grant),
    .strobe_extend(strobe_extend), .acc_end(acc_end),
    .timeout_abort(timeout_abort), .async_ready_input(rdy), .irq(irq));
  awti_mem_model mem (.pclk(pclk), .presetn(presetn), .go(go), .len(len),
    .active_high(pol), .ready(rdy));
  always #4 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_tests++;
    if (seen !== ex) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  // Holds the request until pready is seen high at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Ready stays active n cycles; filter needs time before strobe end
  task acc(input logic [11:0] n);
    @(posedge pclk);
    go  <= 1'b1;
    len <= n;
    @(posedge pclk);
    go  <= 1'b0;
    repeat (6) @(posedge pclk);
    strobe_end <= 1'b1;
    ext = 0;
    e = 1'b0;
    for (int i = 0; i < 300 && !e; i++) begin
      @(negedge pclk);
      if (strobe_extend === 1'b1) ext++;
      to = timeout_abort;
      e = acc_end;
      g = acc_grant;
      @(posedge pclk);
      if (g === 1'b1) strobe_end <= 1'b0;
    end
    gap = 0;
    @(negedge pclk);
    while (acc_grant !== 1'b1 && gap < 40) begin
      gap++;
      @(negedge pclk);
    end
  endtask : acc
  //////////////////////////////////////////////////////////////////////////
  task t_reset;
    apb(1'b0, awti_pkg::OFS_WAIT_CFG, 32'h0);
    chk("cfg", q, 32'h40000380);
    apb(1'b0, awti_pkg::OFS_RAW, 32'h0);
    chk("raw", q, 32'h0);
    apb(1'b0, awti_pkg::OFS_EN_SET, 32'h0);
    chk("en_set", q, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", {31'h0, slv}, 32'h1);
    chk("pready", {31'h0, pready}, 32'h1);
  endtask : t_reset
  task t_ignore;
    acc(12'h028);
    chk("ign_ext", ext, 32'h0);
    chk("ign_gap", gap, 32'h5);
  endtask : t_ignore
  task t_timeout;
    apb(1'b1, awti_pkg::OFS_CS_CTRL, 32'h10000000);
    apb(1'b1, awti_pkg::OFS_WAIT_CFG, {2'b01, 19'h0, 3'h5, 8'h01});
    acc(12'h03C);
    chk("to_ext", ext, 32'd16);
    chk("to_flag", {31'h0, to}, 32'h1);
    chk("to_gap", gap, 32'h7);
    apb(1'b0, awti_pkg::OFS_RAW, 32'h0);
    chk("raw", q, 32'h1);
    apb(1'b0, awti_pkg::OFS_MASKED, 32'h0);
    chk("masked", q, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
  endtask : t_timeout
  task t_flags;
    apb(1'b1, awti_pkg::OFS_RAW, 32'h0);
    apb(1'b0, awti_pkg::OFS_RAW, 32'h0);
    chk("raw_w0", q, 32'h1);
    apb(1'b1, awti_pkg::OFS_RAW, 32'h1);
    apb(1'b0, awti_pkg::OFS_RAW, 32'h0);
    chk("raw_w1", q, 32'h0);
    apb(1'b1, awti_pkg::OFS_EN_SET, 32'h0);
    apb(1'b0, awti_pkg::OFS_EN_SET, 32'h0);
    chk("set_w0", q, 32'h0);
    apb(1'b1, awti_pkg::OFS_EN_SET, 32'h1);
    apb(1'b0, awti_pkg::OFS_EN_CLR, 32'h0);
    chk("clr_rd", q, 32'h1);
  endtask : t_flags
  task t_masked;
    pol <= 1'b0;
    apb(1'b1, awti_pkg::OFS_WAIT_CFG, {2'b00, 19'h0, 3'h0, 8'h01});
    acc(12'h03C);
    chk("lo_to", {31'h0, to}, 32'h1);
    chk("lo_gap", gap, 32'h2);
    apb(1'b0, awti_pkg::OFS_MASKED, 32'h0);
    chk("masked", q, 32'h1);
    chk("irq_on", {31'h0, irq}, 32'h1);
    apb(1'b1, awti_pkg::OFS_MASKED, 32'h0);
    apb(1'b0, awti_pkg::OFS_RAW, 32'h0);
    chk("m_w0", q, 32'h1);
    apb(1'b1, awti_pkg::OFS_MASKED, 32'h1);
    apb(1'b0, awti_pkg::OFS_RAW, 32'h0);
    chk("m_w1", q, 32'h0);
    chk("irq_off", {31'h0, irq}, 32'h0);
  endtask : t_masked
  task t_short;
    acc(12'h00C);
    chk("sh_to", {31'h0, to}, 32'h0);
    chk("sh_ext", {31'h0, ext > 0}, 32'h1);
    chk("sh_gap", gap, 32'h2);
  endtask : t_short
  task t_zero;
    apb(1'b1, awti_pkg::OFS_WAIT_CFG, 32'h0);
    acc(12'h03C);
    chk("z_ext", ext, 32'h1);
    chk("z_to", {31'h0, to}, 32'h1);
  endtask : t_zero
  task t_disable;
    apb(1'b1, awti_pkg::OFS_EN_CLR, 32'h0);
    apb(1'b0, awti_pkg::OFS_EN_SET, 32'h0);
    chk("clr_w0", q, 32'h1);
    apb(1'b1, awti_pkg::OFS_EN_CLR, 32'h1);
    apb(1'b0, awti_pkg::OFS_EN_SET, 32'h0);
    chk("set_off", q, 32'h0);
    apb(1'b0, awti_pkg::OFS_EN_CLR, 32'h0);
    chk("clr_off", q, 32'h0);
  endtask : t_disable
  //////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, strobe_end, go} = 5'h00;
    pol = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    len = 12'h000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ignore();
    t_timeout();
    t_flags();
    t_masked();
    t_short();
    t_zero();
    t_disable();
    close_out();
  end
endmodule : tb
